// >>> rtl/ofbp_pkg.sv
// Shared constants and types for the on-chip flash bus ports
package ofbp_pkg;
  localparam int OFBP_DATA_W = 32;
  localparam int OFBP_ADDR_W = 8;
  localparam int OFBP_BURST_W = 4;
  localparam int OFBP_DEPTH = 256;
  localparam logic [OFBP_BURST_W-1:0] OFBP_BURST_MAX = 4'h8;
  localparam logic [OFBP_BURST_W-1:0] OFBP_BURST_ONE = 4'h1;
  localparam logic [OFBP_ADDR_W-1:0] OFBP_ADDR_ZERO = 8'h00;
  localparam logic [OFBP_ADDR_W-1:0] OFBP_ADDR_ONE = 8'h01;
  localparam logic OFBP_CSR_STATUS = 1'b0;
  localparam logic OFBP_CSR_CONTROL = 1'b1;
  localparam logic [1:0] OFBP_BUSY_IDLE = 2'h0;
  localparam logic [1:0] OFBP_BUSY_ERASE = 2'h1;
  localparam logic [1:0] OFBP_BUSY_WRITE = 2'h2;
  localparam logic [1:0] OFBP_BUSY_READ = 2'h3;
  localparam logic [31:0] OFBP_CTRL_RESET = 32'hFFFFFFFF;
  localparam logic [21:0] OFBP_STATUS_PAD = 22'h3FFFFF;
  localparam logic [4:0] OFBP_SECT_PROT = 5'h00;
  localparam logic [31:0] OFBP_ERASED = 32'hFFFFFFFF;
  localparam logic [31:0] OFBP_ZERO = 32'h00000000;
  localparam logic [2:0] OFBP_WRITE_CYC = 3'h3;
  localparam logic [2:0] OFBP_CNT_ZERO = 3'h0;
  localparam logic [2:0] OFBP_CNT_ONE = 3'h1;
  localparam real OFBP_FMAX_PAR_MHZ = 116.0;
  localparam real OFBP_FMAX_SER_MHZ = 7.25;
  localparam real OFBP_CLK_MHZ = 10.0;
  typedef enum logic [1:0] {
    OFBP_S_IDLE = 2'b00,
    OFBP_S_READ = 2'b01,
    OFBP_S_WRITE = 2'b10
  } ofbp_state_t;
endpackage

// >>> rtl/ofbp_if.sv
// Interface joining the bus master end and the flash port end
`timescale 1ns/1ps
interface ofbp_if
  import ofbp_pkg::*;
  ();
  logic csr_addr;
  logic csr_read;
  logic csr_write;
  logic [OFBP_DATA_W-1:0] csr_writedata;
  logic [OFBP_DATA_W-1:0] csr_readdata;
  logic [OFBP_ADDR_W-1:0] data_addr;
  logic data_read;
  logic data_write;
  logic [OFBP_DATA_W-1:0] data_writedata;
  logic [OFBP_DATA_W-1:0] data_readdata;
  logic data_waitrequest;
  logic data_readdatavalid;
  logic [OFBP_BURST_W-1:0] data_burstcount;
  modport device (
    input csr_addr, csr_read, csr_write, csr_writedata,
    output csr_readdata,
    input data_addr, data_read, data_write, data_writedata, data_burstcount,
    output data_readdata, data_waitrequest, data_readdatavalid
  );
  modport master (
    output csr_addr, csr_read, csr_write, csr_writedata,
    input csr_readdata,
    output data_addr, data_read, data_write, data_writedata, data_burstcount,
    input data_readdata, data_waitrequest, data_readdatavalid
  );
endinterface

// >>> rtl/ofbp_rst_sync.sv
// Reset synchroniser: asynchronous assertion, synchronous release
`timescale 1ns/1ps
module ofbp_rst_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_rst
);
  logic meta_r;
  logic sync_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= 1'b0;
      sync_r <= meta_r;
    end
  end
  assign o_rst = sync_r;
endmodule

// >>> rtl/ofbp_device.sv
// Flash end: control registers and flash data port with bursts
`timescale 1ns/1ps
// Behaviour
// (R1) Clock at most 116 MHz parallel
// (R2) Active-low reset, released synchronously inside
// (R3) One-bit control address, 32-bit data
// (R4) Master strobes read or write
// (R5) Master drives write data during writes
// (R6) Device drives read data on reads
// (R7) Flash address width fixed at build
// (R8) Waitrequest while busy; master holds request
// (R9) Readdatavalid exactly when readdata valid
// (R10) Master gives burst count with read
// (R11) Incrementing burst counts one to maximum
// (R12) Wrapping bursts parallel only, small counts; the code does incrementing bursts only
// (R13) Optional preload, off by default
// (R14) Address 0 status, address 1 control
// (R15) Parallel writes are single-word
module ofbp_device
  import ofbp_pkg::*;
#(
  parameter bit INIT_CONTENT = 1'b0,
  parameter logic [OFBP_DATA_W-1:0] INIT_WORD = 32'h00000000
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  ofbp_if.device bus
);
  logic rst;
  ofbp_state_t state_r;
  logic [OFBP_DATA_W-1:0] mem_r [OFBP_DEPTH];
  logic [OFBP_DATA_W-1:0] ctrl_r;
  logic [OFBP_DATA_W-1:0] csr_rd_r;
  logic [OFBP_DATA_W-1:0] rd_data_r;
  logic rd_valid_r;
  logic [OFBP_ADDR_W-1:0] addr_r;
  logic [OFBP_BURST_W-1:0] left_r;
  logic [2:0] wcnt_r;
  logic rs_r;
  logic ws_r;
  logic [OFBP_DATA_W-1:0] wdata_r;
  logic [1:0] busy_code;
  logic accept;
  logic take_rd;
  logic take_wr;
  logic last_beat;
  logic write_done;

  function automatic logic burst_ok(input logic [OFBP_BURST_W-1:0] n);
    burst_ok = (n != '0) && (n <= OFBP_BURST_MAX);
  endfunction

  // Keeps async assert but removes release hazard
  ofbp_rst_sync u_rst_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .o_rst(rst)
  ); // [R2]

  assign accept = (state_r == OFBP_S_IDLE);
  assign bus.data_waitrequest = !accept; // [R8]
  assign bus.data_readdata = rd_data_r; // [R6]
  assign bus.data_readdatavalid = rd_valid_r; // [R9]
  assign bus.csr_readdata = csr_rd_r;

  always_comb begin
    case (state_r)
      OFBP_S_READ: busy_code = OFBP_BUSY_READ;
      OFBP_S_WRITE: busy_code = OFBP_BUSY_WRITE;
      default: busy_code = OFBP_BUSY_IDLE;
    endcase
  end

  // Only an idle port takes a request; out-of-range bursts are dropped
  assign take_rd = accept && bus.data_read && burst_ok(bus.data_burstcount); // [R11] [R12]
  assign take_wr = accept && !bus.data_read && bus.data_write; // [R15]
  assign last_beat = (state_r == OFBP_S_READ) && (left_r == OFBP_BURST_ONE);
  assign write_done = (state_r == OFBP_S_WRITE) && (wcnt_r == OFBP_CNT_ONE);

  // Sequencer state
  always_ff @(posedge i_clk) begin
    if (rst) begin
      state_r <= OFBP_S_IDLE;
    end else begin
      case (state_r)
        OFBP_S_IDLE: begin
          if (take_rd) begin
            state_r <= OFBP_S_READ;
          end else if (take_wr) begin
            state_r <= OFBP_S_WRITE;
          end
        end
        OFBP_S_READ: begin
          if (last_beat) begin
            state_r <= OFBP_S_IDLE;
          end
        end
        OFBP_S_WRITE: begin
          if (write_done) begin
            state_r <= OFBP_S_IDLE;
          end
        end
        default: state_r <= OFBP_S_IDLE;
      endcase
    end
  end

  // Word address; steps once per beat, no wrapping
  always_ff @(posedge i_clk) begin
    if (rst) begin
      addr_r <= OFBP_ADDR_ZERO;
    end else if (take_rd || take_wr) begin
      addr_r <= bus.data_addr; // [R7]
    end else if (state_r == OFBP_S_READ) begin
      addr_r <= addr_r + OFBP_ADDR_ONE;
    end
  end

  // Words still to return in the burst
  always_ff @(posedge i_clk) begin
    if (rst) begin
      left_r <= '0;
    end else if (take_rd) begin
      left_r <= bus.data_burstcount; // [R10]
    end else if (state_r == OFBP_S_READ) begin
      left_r <= left_r - OFBP_BURST_ONE;
    end
  end

  // Program time, a fixed stand-in for the cell timing
  always_ff @(posedge i_clk) begin
    if (rst) begin
      wcnt_r <= OFBP_CNT_ZERO;
    end else if (take_wr) begin
      wcnt_r <= OFBP_WRITE_CYC;
    end else if (state_r == OFBP_S_WRITE) begin
      wcnt_r <= wcnt_r - OFBP_CNT_ONE;
    end
  end

  // Write word latched so the master may drop it at once
  always_ff @(posedge i_clk) begin
    if (rst) begin
      wdata_r <= OFBP_ZERO;
    end else if (take_wr) begin
      wdata_r <= bus.data_writedata; // [R5]
    end
  end

  // Read return, one word per cycle of the burst
  always_ff @(posedge i_clk) begin
    if (rst) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= (state_r == OFBP_S_READ); // [R9]
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      rd_data_r <= OFBP_ZERO;
    end else if (state_r == OFBP_S_READ) begin
      rd_data_r <= mem_r[addr_r]; // [R6]
    end
  end

  // Flash array; flash programming only clears bits
  always_ff @(posedge i_clk) begin
    if (rst) begin
      for (int i = 0; i < OFBP_DEPTH; i++) begin
        mem_r[i] <= INIT_CONTENT ? INIT_WORD : OFBP_ERASED; // [R13]
      end
    end else if (write_done) begin
      mem_r[addr_r] <= mem_r[addr_r] & wdata_r;
    end
  end

  // Read result of the last read request seen while idle
  always_ff @(posedge i_clk) begin
    if (rst) begin
      rs_r <= 1'b0;
    end else if (accept && bus.data_read) begin
      rs_r <= burst_ok(bus.data_burstcount); // [R11]
    end
  end

  // Sticky; no erase path exists to clear it
  always_ff @(posedge i_clk) begin
    if (rst) begin
      ws_r <= 1'b0;
    end else if (take_wr) begin
      ws_r <= 1'b1;
    end
  end

  // Control word
  always_ff @(posedge i_clk) begin
    if (rst) begin
      ctrl_r <= OFBP_CTRL_RESET;
    end else if (bus.csr_write && bus.csr_addr == OFBP_CSR_CONTROL) begin // [R3] [R14]
      ctrl_r <= bus.csr_writedata;
    end
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (rst) begin
      csr_rd_r <= OFBP_ZERO;
    end else if (bus.csr_read) begin
      if (bus.csr_addr == OFBP_CSR_STATUS) begin // [R14]
        csr_rd_r <= {OFBP_STATUS_PAD, OFBP_SECT_PROT, 1'b0, ws_r, rs_r, busy_code};
      end else begin
        csr_rd_r <= ctrl_r; // [R3]
      end
    end
  end
endmodule

// >>> rtl/ofbp_master.sv
// Master end: turns user commands into bus transfers
`timescale 1ns/1ps
module ofbp_master
  import ofbp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_is_write,
  input wire logic i_is_csr,
  input wire logic [OFBP_ADDR_W-1:0] i_addr,
  input wire logic [OFBP_DATA_W-1:0] i_wdata,
  input wire logic [OFBP_BURST_W-1:0] i_burst,
  output logic o_busy,
  output logic [OFBP_DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  ofbp_if.master bus
);
  logic active_r;
  logic csr_rd_pend_r;
  // Held until waitrequest falls
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      active_r <= 1'b0;
      bus.data_read <= 1'b0;
      bus.data_write <= 1'b0;
      bus.data_addr <= OFBP_ADDR_ZERO;
      bus.data_writedata <= OFBP_ZERO;
      bus.data_burstcount <= OFBP_BURST_ONE;
      bus.csr_read <= 1'b0;
      bus.csr_write <= 1'b0;
      bus.csr_addr <= OFBP_CSR_STATUS;
      bus.csr_writedata <= OFBP_ZERO;
    end else begin
      bus.csr_read <= 1'b0;
      bus.csr_write <= 1'b0;
      if (active_r && !bus.data_waitrequest) begin // [R8]
        active_r <= 1'b0;
        bus.data_read <= 1'b0;
        bus.data_write <= 1'b0;
      end else if (!active_r && i_req) begin
        if (i_is_csr) begin
          bus.csr_addr <= i_addr[0]; // [R3]
          bus.csr_writedata <= i_wdata; // [R5]
          bus.csr_read <= !i_is_write; // [R4]
          bus.csr_write <= i_is_write;
        end else begin
          active_r <= 1'b1;
          bus.data_addr <= i_addr;
          bus.data_writedata <= i_wdata; // [R5]
          bus.data_read <= !i_is_write; // [R4]
          bus.data_write <= i_is_write;
          bus.data_burstcount <= i_is_write ? OFBP_BURST_ONE : i_burst; // [R10] [R15]
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      csr_rd_pend_r <= 1'b0;
      o_rdata <= OFBP_ZERO;
      o_rvalid <= 1'b0;
    end else begin
      csr_rd_pend_r <= bus.csr_read;
      o_rvalid <= bus.data_readdatavalid || csr_rd_pend_r;
      o_rdata <= csr_rd_pend_r ? bus.csr_readdata : bus.data_readdata;
    end
  end
  assign o_busy = active_r;
endmodule

// >>> tb/ofbp_chk.sv
// Assertions on the interface between the two ends
`timescale 1ns/1ps
module ofbp_chk
  import ofbp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic csr_addr,
  input wire logic csr_read,
  input wire logic [OFBP_DATA_W-1:0] csr_readdata,
  input wire logic data_read,
  input wire logic data_write,
  input wire logic data_waitrequest,
  input wire logic data_readdatavalid,
  input wire logic [OFBP_BURST_W-1:0] data_burstcount
);
  logic [OFBP_BURST_W-1:0] pend_r;
  logic take_rd;
  logic bad_rd;
  assign take_rd = data_read && !data_waitrequest && data_burstcount != 4'h0
    && data_burstcount <= OFBP_BURST_MAX;
  assign bad_rd = data_read && !data_waitrequest && !take_rd;
  // Words still owed, so extra beats show up
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pend_r <= 4'h0;
    end else if (take_rd) begin
      pend_r <= data_burstcount;
    end else if (data_readdatavalid && pend_r != 4'h0) begin
      pend_r <= pend_r - 4'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  take_wait_a: assert property (take_rd |=> data_waitrequest)
    else $error("read taken without wait");
  first_word_a: assert property (take_rd |-> ##1 !data_readdatavalid ##1 data_readdatavalid)
    else $error("first word not two cycles after take");
  single_end_a: assert property (take_rd && data_burstcount == 4'h1
    |-> ##2 data_readdatavalid ##1 !data_readdatavalid)
    else $error("single read gave wrong beat count");
  wait_hold_a: assert property (pend_r > 4'h1 |-> data_waitrequest)
    else $error("wait dropped mid burst");
  valid_owed_a: assert property (data_readdatavalid |-> pend_r != 4'h0)
    else $error("valid with no word owed");
  write_wait_a: assert property (data_write && !data_waitrequest
    |=> data_waitrequest[*3] ##1 !data_waitrequest)
    else $error("write wait length wrong");
  bad_refused_a: assert property (bad_rd |=> !data_waitrequest ##1 !data_readdatavalid)
    else $error("bad burst count not refused");
  status_pad_a: assert property (csr_read && !csr_addr
    |=> csr_readdata[31:4] == 28'hFFFFFC0)
    else $error("status padding wrong");
endmodule

// >>> tb/tb.sv
// Testbench joining both ends and driving the master user side
`timescale 1ns/1ps
module tb;
  import ofbp_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_rst_n;
  logic i_req = 1'b0;
  logic i_is_write = 1'b0;
  logic i_is_csr = 1'b0;
  logic [OFBP_ADDR_W-1:0] i_addr = OFBP_ADDR_ZERO;
  logic [OFBP_DATA_W-1:0] i_wdata = OFBP_ZERO;
  logic [OFBP_BURST_W-1:0] i_burst = OFBP_BURST_ONE;
  logic o_busy;
  logic o_rvalid;
  logic [OFBP_DATA_W-1:0] o_rdata;
  int n_mismatch = 0;
  int num_checks = 0;
  // Well under the parallel-mode ceiling
  always #(500.0 / OFBP_CLK_MHZ) i_clk = ~i_clk;
  assign i_rst_n = ~i_rst;
  ofbp_if ofbp_if_i ();
  ofbp_device ofbp_device_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(ofbp_if_i.device));
  ofbp_master ofbp_master_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
    .i_is_write(i_is_write), .i_is_csr(i_is_csr), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_burst(i_burst), .o_busy(o_busy), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .bus(ofbp_if_i.master));
  ofbp_chk ofbp_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .csr_addr(ofbp_if_i.csr_addr),
    .csr_read(ofbp_if_i.csr_read), .csr_readdata(ofbp_if_i.csr_readdata),
    .data_read(ofbp_if_i.data_read), .data_write(ofbp_if_i.data_write),
    .data_waitrequest(ofbp_if_i.data_waitrequest),
    .data_readdatavalid(ofbp_if_i.data_readdatavalid),
    .data_burstcount(ofbp_if_i.data_burstcount));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One user command; counts and checks every returned word
  task automatic op(input logic wr, input logic csr, input logic [7:0] a,
    input logic [31:0] wd, input logic [3:0] b, input logic [31:0] exp, input int n);
    int got;
    got = 0;
    @(posedge i_clk);
    i_req <= 1'b1;
    i_is_write <= wr;
    i_is_csr <= csr;
    i_addr <= a;
    i_wdata <= wd;
    i_burst <= b;
    @(posedge i_clk);
    i_req <= 1'b0;
    for (int k = 0; k < 40; k++) begin
      @(posedge i_clk);
      #1;
      if (o_rvalid === 1'b1) begin
        got++;
        check(o_rdata, exp);
      end
    end
    check(32'(got), 32'(n));
    check(32'(o_busy), 32'h00000000);
    if (o_busy !== 1'b0) begin
      end_sim();
    end
  endtask
  task automatic do_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic t_csr();
    op(1'b0, 1'b1, 8'h00, 32'h0, 4'h1, 32'hFFFFFC00, 1);
    op(1'b0, 1'b1, 8'h01, 32'h0, 4'h1, OFBP_CTRL_RESET, 1);
    op(1'b1, 1'b1, 8'h01, 32'h12345678, 4'h1, 32'h0, 0);
    op(1'b0, 1'b1, 8'h01, 32'h0, 4'h1, 32'h12345678, 1);
  endtask
  task automatic t_bursts();
    op(1'b0, 1'b0, 8'h10, 32'h0, 4'h1, OFBP_ERASED, 1);
    op(1'b0, 1'b0, 8'hF8, 32'h0, 4'h8, OFBP_ERASED, 8);
  endtask
  // Writes only clear bits, so a second write ANDs in
  task automatic t_write();
    op(1'b1, 1'b0, 8'h05, 32'hA5A50F0F, 4'h1, 32'h0, 0);
    op(1'b0, 1'b0, 8'h05, 32'h0, 4'h1, 32'hA5A50F0F, 1);
    op(1'b1, 1'b0, 8'h05, 32'h0FF0FFFF, 4'h1, 32'h0, 0);
    op(1'b0, 1'b0, 8'h05, 32'h0, 4'h1, 32'h05A00F0F, 1);
    op(1'b0, 1'b0, 8'h04, 32'h0, 4'h1, OFBP_ERASED, 1);
    op(1'b0, 1'b1, 8'h00, 32'h0, 4'h1, 32'hFFFFFC0C, 1);
  endtask
  task automatic t_refuse();
    op(1'b0, 1'b0, 8'h20, 32'h0, 4'h0, 32'h0, 0);
    op(1'b0, 1'b0, 8'h20, 32'h0, 4'h9, 32'h0, 0);
    op(1'b0, 1'b1, 8'h00, 32'h0, 4'h1, 32'hFFFFFC08, 1);
  endtask
  // Mid-run reset must restore control word and flash array
  task automatic t_reset();
    do_reset();
    op(1'b0, 1'b1, 8'h01, 32'h0, 4'h1, OFBP_CTRL_RESET, 1);
    op(1'b0, 1'b0, 8'h05, 32'h0, 4'h1, OFBP_ERASED, 1);
  endtask
  initial begin
    do_reset();
    t_csr();
    t_bursts();
    t_write();
    t_refuse();
    t_reset();
    end_sim();
  end
endmodule
